// ===== hdl/tcc_pkg.sv
package tcc_pkg;
   // Byte offsets of the register words
   localparam logic [5:0] OFS_CAPTURE_A = 6'h00;
   localparam logic [5:0] OFS_CAPTURE_B = 6'h04;
   localparam logic [5:0] OFS_COMPARE_A = 6'h08;
   localparam logic [5:0] OFS_COMPARE_B = 6'h0C;
   localparam logic [5:0] OFS_COUNTER = 6'h10;
   localparam logic [5:0] OFS_CONTROL_ONE = 6'h14;
   localparam logic [5:0] OFS_CONTROL_TWO = 6'h18;
   localparam logic [5:0] OFS_FLAGS = 6'h1C;
   localparam logic [5:0] OFS_LAST = 6'h1C;
   // control_one fields
   localparam int C1_EXT_SEL = 0;
   localparam int C1_EXT_EDGE = 1;
   localparam int C1_CAPA_EDGE = 2;
   localparam int C1_CAPB_EDGE = 3;
   localparam int C1_CMPA_OE = 4;
   localparam int C1_CMPB_OE = 5;
   localparam int C1_CMPA_LVL = 6;
   localparam int C1_CMPB_LVL = 7;
   localparam int C1_W = 8;
   // control_two fields
   localparam int C2_DIV_LSB = 0;
   localparam int C2_DIV_W = 8;
   localparam int C2_CAPA_IE = 8;
   localparam int C2_CAPB_IE = 9;
   localparam int C2_CMPA_IE = 10;
   localparam int C2_CMPB_IE = 11;
   localparam int C2_OVF_IE = 12;
   localparam int C2_W = 13;
   // flag_register fields
   localparam int FL_CAPA = 15;
   localparam int FL_CMPA = 14;
   localparam int FL_OVF = 13;
   localparam int FL_CAPB = 12;
   localparam int FL_CMPB = 11;
   // Reset and forced values
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] CNT_FORCED = 16'hFFFC;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CMP_RESET = 16'h8000;
   localparam logic [15:0] CAP_RESET = 16'h0000;
   localparam logic [C1_W-1:0] C1_RESET = 8'h00;
   localparam logic [C2_W-1:0] C2_RESET = 13'h0000;
   localparam logic [2:0] EXT_PREDIV_LAST = 3'h7;
   localparam int EXT_MIN_GAP = 4;
endpackage

// ===== hdl/tcc_timer.sv
`timescale 1ns/1ps
// How it works
// - Internal tick is clock over divider plus one
// - Any counter write forces FFFC
// - Select bit picks internal or external clock
// - Wrap from maximum sets overflow flag
// - Overflow request while flag and enable set
// - Flag register: written zero clears, one keeps
// - Edge select picks external clock transition
// - External clock synchronised; four edges apart
// - Capture latches counter on active pin edge
// - Per-channel capture edge select bit
// - Capture sets flag; request when enabled
// - Compare on each tick sets flag
// - Compare registers software only, reset 8000
// - Enabled match drives level onto pin
// - Disabled output holds pin at zero
// - Five requests, separate and ORed together
// - First instance divides external clock by eight
module tcc_timer #(
   parameter bit FIRST_INSTANCE = 1'b1
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic ext_clock_pin,
   input wire logic capture_a_pin,
   input wire logic capture_b_pin,
   output logic compare_a_pin,
   output logic compare_b_pin,
   output logic irq_capture_a,
   output logic irq_capture_b,
   output logic irq_compare_a,
   output logic irq_compare_b,
   output logic irq_overflow,
   output logic irq_any
);
   import tcc_pkg::*;

   if (FIRST_INSTANCE !== 1'b0 && FIRST_INSTANCE !== 1'b1) begin : g_chk
      $error("FIRST_INSTANCE must be 0 or 1");
   end

   logic wait_r;
   logic [31:0] rdata_r;
   logic [15:0] counter_value_reg;
   logic [15:0] compare_a_value, compare_b_value, capture_a_value, capture_b_value;
   logic [C1_W-1:0] control_one;
   logic [C2_W-1:0] control_two;
   logic [15:0] flag_register;
   logic [7:0] pre_cnt_r;
   logic [2:0] ext_sync_r, capa_sync_r, capb_sync_r;
   logic [2:0] ext_div_r;
   logic cmpa_pin_r, cmpb_pin_r;
   logic [4:0] irq_r;
   logic irq_any_r;
   logic bus_wr, bus_rd, cnt_wr, flag_wr;
   logic ext_edge, ext_evt, int_tick, tick;
   logic capa_evt, capb_evt, cmpa_hit, cmpb_hit, ovf_hit;
   logic [15:0] flag_set, flag_clr;
   logic [4:0] irq_nxt;
   logic [7:0] divider;

   assign bus_wr = write & ~wait_r;
   assign bus_rd = read & ~wait_r;
   assign cnt_wr = bus_wr && address[5:2] == OFS_COUNTER[5:2];
   assign flag_wr = bus_wr && address[5:2] == OFS_FLAGS[5:2];
   assign divider = control_two[C2_DIV_LSB +: C2_DIV_W];

   // One wait cycle, then the access completes
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wait_r <= 1'b1;
      end else begin
         wait_r <= ~((read | write) & wait_r);
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata_r <= 32'h0000_0000;
      end else if (read & wait_r) begin
         unique case (address[5:2])
            OFS_CAPTURE_A[5:2]: rdata_r <= {16'h0000, capture_a_value};
            OFS_CAPTURE_B[5:2]: rdata_r <= {16'h0000, capture_b_value};
            OFS_COMPARE_A[5:2]: rdata_r <= {16'h0000, compare_a_value};
            OFS_COMPARE_B[5:2]: rdata_r <= {16'h0000, compare_b_value};
            OFS_COUNTER[5:2]: rdata_r <= {16'h0000, counter_value_reg};
            OFS_CONTROL_ONE[5:2]: rdata_r <= {24'h000000, control_one};
            OFS_CONTROL_TWO[5:2]: rdata_r <= {19'h00000, control_two};
            OFS_FLAGS[5:2]: rdata_r <= {16'h0000, flag_register};
            default: rdata_r <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         control_one <= C1_RESET;
         control_two <= C2_RESET;
      end else if (bus_wr && address[5:2] == OFS_CONTROL_ONE[5:2]) begin
         control_one <= writedata[C1_W-1:0];
      end else if (bus_wr && address[5:2] == OFS_CONTROL_TWO[5:2]) begin
         control_two <= writedata[C2_W-1:0];
      end
   end

   // Only software writes the compare registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         compare_a_value <= CMP_RESET;
         compare_b_value <= CMP_RESET;
      end else if (bus_wr && address[5:2] == OFS_COMPARE_A[5:2]) begin
         compare_a_value <= writedata[15:0];
      end else if (bus_wr && address[5:2] == OFS_COMPARE_B[5:2]) begin
         compare_b_value <= writedata[15:0];
      end
   end

   // Pin synchronisers; bit 0 is read only by bit 1
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ext_sync_r <= 3'h0;
         capa_sync_r <= 3'h0;
         capb_sync_r <= 3'h0;
      end else begin
         ext_sync_r <= {ext_sync_r[1:0], ext_clock_pin};
         capa_sync_r <= {capa_sync_r[1:0], capture_a_pin};
         capb_sync_r <= {capb_sync_r[1:0], capture_b_pin};
      end
   end

   // Edge select 1 means rising, 0 falling
   assign ext_edge = control_one[C1_EXT_EDGE] ? (ext_sync_r[1] & ~ext_sync_r[2])
                                              : (~ext_sync_r[1] & ext_sync_r[2]);
   assign capa_evt = control_one[C1_CAPA_EDGE] ? (capa_sync_r[1] & ~capa_sync_r[2])
                                               : (~capa_sync_r[1] & capa_sync_r[2]);
   assign capb_evt = control_one[C1_CAPB_EDGE] ? (capb_sync_r[1] & ~capb_sync_r[2])
                                               : (~capb_sync_r[1] & capb_sync_r[2]);

   // Fixed divide by eight of external edges on the first instance
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ext_div_r <= 3'h0;
      end else if (ext_edge && FIRST_INSTANCE) begin
         ext_div_r <= ext_div_r + 3'h1;
      end
   end
   assign ext_evt = ext_edge && (!FIRST_INSTANCE || ext_div_r == EXT_PREDIV_LAST);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pre_cnt_r <= 8'h00;
      end else if (control_one[C1_EXT_SEL] || pre_cnt_r >= divider) begin
         pre_cnt_r <= 8'h00;
      end else begin
         pre_cnt_r <= pre_cnt_r + 8'h01;
      end
   end
   assign int_tick = pre_cnt_r >= divider;
   assign tick = control_one[C1_EXT_SEL] ? ext_evt : int_tick;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         counter_value_reg <= CNT_RESET;
      end else if (cnt_wr) begin
         counter_value_reg <= CNT_FORCED;
      end else if (tick) begin
         counter_value_reg <= counter_value_reg + 16'h0001;
      end
   end

   assign ovf_hit = tick && !cnt_wr && counter_value_reg == CNT_MAX;
   assign cmpa_hit = tick && counter_value_reg == compare_a_value;
   assign cmpb_hit = tick && counter_value_reg == compare_b_value;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         capture_a_value <= CAP_RESET;
         capture_b_value <= CAP_RESET;
      end else begin
         if (capa_evt) begin
            capture_a_value <= counter_value_reg;
         end
         if (capb_evt) begin
            capture_b_value <= counter_value_reg;
         end
      end
   end

   always_comb begin
      flag_set = 16'h0000;
      flag_set[FL_CAPA] = capa_evt;
      flag_set[FL_CAPB] = capb_evt;
      flag_set[FL_CMPA] = cmpa_hit;
      flag_set[FL_CMPB] = cmpb_hit;
      flag_set[FL_OVF] = ovf_hit;
   end
   assign flag_clr = flag_wr ? ~writedata[15:0] : 16'h0000;

   // A new event in the clearing cycle survives
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flag_register <= 16'h0000;
      end else begin
         flag_register <= (flag_register & ~flag_clr) | flag_set;
      end
   end

   // Pins follow the level on a match, held low when disabled
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cmpa_pin_r <= 1'b0;
         cmpb_pin_r <= 1'b0;
      end else begin
         if (!control_one[C1_CMPA_OE]) begin
            cmpa_pin_r <= 1'b0;
         end else if (cmpa_hit) begin
            cmpa_pin_r <= control_one[C1_CMPA_LVL];
         end
         if (!control_one[C1_CMPB_OE]) begin
            cmpb_pin_r <= 1'b0;
         end else if (cmpb_hit) begin
            cmpb_pin_r <= control_one[C1_CMPB_LVL];
         end
      end
   end

   assign irq_nxt = {flag_register[FL_OVF] & control_two[C2_OVF_IE],
                     flag_register[FL_CMPB] & control_two[C2_CMPB_IE],
                     flag_register[FL_CMPA] & control_two[C2_CMPA_IE],
                     flag_register[FL_CAPB] & control_two[C2_CAPB_IE],
                     flag_register[FL_CAPA] & control_two[C2_CAPA_IE]};

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_r <= 5'h00;
         irq_any_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
         irq_any_r <= |irq_nxt;
      end
   end

   assign readdata = rdata_r;
   assign waitrequest = wait_r;
   assign compare_a_pin = cmpa_pin_r;
   assign compare_b_pin = cmpb_pin_r;
   assign irq_capture_a = irq_r[0];
   assign irq_capture_b = irq_r[1];
   assign irq_compare_a = irq_r[2];
   assign irq_compare_b = irq_r[3];
   assign irq_overflow = irq_r[4];
   assign irq_any = irq_any_r;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   sequence s_int_div1;
      tick && !control_one[C1_EXT_SEL] && divider == 8'h01;
   endsequence
   sequence s_ctl_still;
      $stable(control_two) && $stable(control_one);
   endsequence

   counter_force_a: assert property (cnt_wr |=> counter_value_reg == CNT_FORCED)
      else $error("counter write did not force FFFC");
   prescale_two_a: assert property (s_int_div1 ##1 s_ctl_still ##1 s_ctl_still |->
      tick && !$past(tick))
      else $error("divide by two tick spacing wrong");
   ext_tick_a: assert property (tick && control_one[C1_EXT_SEL] |->
      ext_sync_r[1] != ext_sync_r[2] && ext_sync_r[1] == control_one[C1_EXT_EDGE])
      else $error("external tick without selected edge");
   count_step_a: assert property (tick && !cnt_wr |=>
      counter_value_reg == $past(counter_value_reg) + 16'h0001)
      else $error("counter did not step on tick");
   overflow_set_a: assert property (ovf_hit |=> flag_register[FL_OVF])
      else $error("overflow flag not set on wrap");
   overflow_irq_a: assert property (flag_register[FL_OVF] && control_two[C2_OVF_IE]
      |=> irq_overflow && irq_any)
      else $error("overflow request missing");
   flag_keep_a: assert property (flag_wr && writedata[FL_OVF] && flag_register[FL_OVF]
      |=> flag_register[FL_OVF])
      else $error("written one cleared overflow flag");
   capture_latch_a: assert property (capa_evt |=>
      capture_a_value == $past(counter_value_reg) && flag_register[FL_CAPA])
      else $error("capture A did not latch counter");
   compare_flag_a: assert property (cmpb_hit |=> flag_register[FL_CMPB])
      else $error("compare B flag not set");
   compare_level_a: assert property (cmpa_hit && control_one[C1_CMPA_OE] |=>
      compare_a_pin == $past(control_one[C1_CMPA_LVL]))
      else $error("compare A pin missed level");
   compare_off_a: assert property (!control_one[C1_CMPB_OE] |=> !compare_b_pin)
      else $error("disabled compare B pin not low");
endmodule

// ===== test/tcc_far_end.sv
`timescale 1ns/1ps
module tcc_far_end (
   input wire logic mclk,
   output logic ext_clock_pin,
   output logic capture_a_pin,
   output logic capture_b_pin
);
   initial begin
      ext_clock_pin = 1'b0;
      capture_a_pin = 1'b0;
      capture_b_pin = 1'b0;
   end
   // Active edges stay more than the minimum gap apart; idle level is low
   task automatic ext_pulses(input int n);
      repeat (n) begin
         @(posedge mclk);
         ext_clock_pin <= 1'b1;
         repeat (4) @(posedge mclk);
         ext_clock_pin <= 1'b0;
         repeat (4) @(posedge mclk);
      end
   endtask
   task automatic set_capture(input logic ch, input logic lvl);
      @(posedge mclk);
      if (ch) capture_b_pin <= lvl;
      else capture_a_pin <= lvl;
   endtask
endmodule

// ===== test/tcc_timer_test.sv
`timescale 1ns/1ps
module tcc_timer_test;
   import tcc_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [5:0] address = 6'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata, rv, e, m;
   logic waitrequest, ext_clock_pin, capture_a_pin, capture_b_pin;
   logic compare_a_pin, compare_b_pin, irq_capture_a, irq_capture_b;
   logic irq_compare_a, irq_compare_b, irq_overflow, irq_any;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int d;
   logic [31:0] exp_q[$];
   logic [31:0] mask_q[$];
   always #20 mclk = ~mclk;
   tcc_timer u_tcc_timer (.mclk, .rst, .address, .read, .write, .writedata, .readdata,
      .waitrequest, .ext_clock_pin, .capture_a_pin, .capture_b_pin, .compare_a_pin,
      .compare_b_pin, .irq_capture_a, .irq_capture_b, .irq_compare_a, .irq_compare_b,
      .irq_overflow, .irq_any);
   tcc_far_end u_tcc_far_end (.mclk, .ext_clock_pin, .capture_a_pin, .capture_b_pin);
   task automatic fail(input string s);
      err_count++;
      $display("wrong value at %0t: %s", $time, s);
   endtask
   task automatic pin(input logic got, input logic want, input string s);
      comparisons++;
      if (got !== want) fail(s);
   endtask
   task automatic complete_run();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Avalon master: request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] dat,
         output logic [31:0] q);
      @(posedge mclk);
      read <= ~wr;
      write <= wr;
      address <= a;
      writedata <= dat;
      do @(posedge mclk); while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] dat);
      logic [31:0] q;
      bus(1'b1, a, dat, q);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] ex, input logic [31:0] mk);
      logic [31:0] q;
      exp_q.push_back(ex & mk);
      mask_q.push_back(mk);
      bus(1'b0, a, 32'h0, q);
   endtask
   // Read results are matched against the oldest note in the queue
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fail("timeout");
         complete_run();
      end else if (read && waitrequest === 1'b0 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         m = mask_q.pop_front();
         comparisons++;
         if ((readdata & m) !== e) fail("register read");
      end
   end
   initial begin
      void'($urandom(37138));
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      rd(OFS_COMPARE_A, 32'h8000, '1);
      rd(OFS_COMPARE_B, 32'h8000, '1);
      rd(OFS_FLAGS, 32'h0, '1);
      rv = $urandom;
      wr(OFS_COMPARE_B, rv);
      rd(OFS_COMPARE_B, {16'h0, rv[15:0]}, '1);
      wr(OFS_CAPTURE_A, rv);
      rd(OFS_CAPTURE_A, 32'h0, '1);
      rd(6'h20, 32'h0, '1);
      // Divider: a window of (d+1)*32 clocks holds exactly 32 ticks; random, then two
      d = $urandom % 256;
      repeat (2) begin
         wr(OFS_CONTROL_TWO, d);
         bus(1'b0, OFS_COUNTER, 32'h0, rv);
         repeat ((d + 1) * 32 - 3) @(posedge mclk);
         rd(OFS_COUNTER, rv + 32, 32'hFFFF);
         d = 1;
      end
      wr(OFS_CONTROL_TWO, 32'hFF);
      wr(OFS_COUNTER, $urandom);
      rd(OFS_COUNTER, 32'hFFFC, 32'hFFFE);
      // Overflow, pending while masked
      wr(OFS_CONTROL_TWO, 32'h0);
      wr(OFS_COUNTER, 32'h0);
      repeat (10) @(posedge mclk);
      pin(irq_overflow, 1'b0, "overflow masked");
      rd(OFS_FLAGS, 32'h2000, 32'h2000);
      wr(OFS_CONTROL_TWO, 32'h1000);
      repeat (3) @(posedge mclk);
      pin(irq_overflow, 1'b1, "overflow pending");
      pin(irq_any, 1'b1, "combined request");
      wr(OFS_FLAGS, 32'hFFFFDFFF);
      repeat (3) @(posedge mclk);
      pin(irq_overflow, 1'b0, "overflow cleared");
      rd(OFS_FLAGS, 32'h0, 32'h2000);
      // Compare: A output enabled, B disabled, both levels high
      pin(compare_a_pin, 1'b0, "pin A before match");
      wr(OFS_COMPARE_A, 32'hFFFE);
      wr(OFS_COMPARE_B, 32'hFFFE);
      wr(OFS_CONTROL_ONE, 32'hD0);
      wr(OFS_CONTROL_TWO, 32'h0C00);
      wr(OFS_COUNTER, 32'h0);
      repeat (10) @(posedge mclk);
      pin(compare_a_pin, 1'b1, "pin A level");
      pin(compare_b_pin, 1'b0, "pin B disabled");
      pin(irq_compare_a, 1'b1, "compare A request");
      pin(irq_compare_b, 1'b1, "compare B request");
      rd(OFS_FLAGS, 32'h4800, 32'h4800);
      wr(OFS_FLAGS, 32'hFFFFB7FF);
      rd(OFS_FLAGS, 32'h0, 32'h4800);
      // Reload compare A with a new value and level, then match again
      wr(OFS_CONTROL_ONE, 32'h10);
      wr(OFS_COMPARE_A, 32'hFFFD);
      pin(compare_a_pin, 1'b1, "pin A held until match");
      wr(OFS_COUNTER, 32'h0);
      repeat (10) @(posedge mclk);
      pin(compare_a_pin, 1'b0, "pin A new level");
      rd(OFS_COMPARE_A, 32'hFFFD, '1);
      // Capture: A on rising, B on falling, slow counter
      wr(OFS_CONTROL_ONE, 32'h04);
      wr(OFS_CONTROL_TWO, 32'h01FF);
      wr(OFS_COUNTER, 32'h0);
      u_tcc_far_end.set_capture(1'b0, 1'b1);
      u_tcc_far_end.set_capture(1'b1, 1'b1);
      repeat (6) @(posedge mclk);
      pin(irq_capture_a, 1'b1, "capture A request");
      rd(OFS_CAPTURE_A, 32'hFFFC, 32'hFFFE);
      rd(OFS_CAPTURE_B, 32'h0, '1);
      u_tcc_far_end.set_capture(1'b1, 1'b0);
      repeat (6) @(posedge mclk);
      rd(OFS_CAPTURE_B, 32'hFFFC, 32'hFFFE);
      rd(OFS_FLAGS, 32'h9000, 32'h9000);
      pin(irq_capture_b, 1'b0, "capture B masked");
      wr(OFS_CONTROL_TWO, 32'h03FF);
      repeat (3) @(posedge mclk);
      pin(irq_capture_b, 1'b1, "capture B pending");
      wr(OFS_FLAGS, 32'hFFFF6FFF);
      rd(OFS_FLAGS, 32'h0, 32'h9000);
      // External clock through the divide-by-eight stage
      wr(OFS_CONTROL_ONE, 32'h03);
      wr(OFS_COUNTER, 32'h0);
      u_tcc_far_end.ext_pulses(16);
      repeat (6) @(posedge mclk);
      rd(OFS_COUNTER, 32'hFFFE, '1);
      wr(OFS_CONTROL_ONE, 32'h01);
      wr(OFS_COUNTER, 32'h0);
      u_tcc_far_end.ext_pulses(8);
      repeat (6) @(posedge mclk);
      rd(OFS_COUNTER, 32'hFFFD, '1);
      complete_run();
   end
endmodule
